// [hw/epl_pkg.sv]
// Purpose: shared constants and types for the energy pulse and line-cycle block
// Assumes: 32-bit APB data, byte addresses, 250 MHz pclk
// Notes: all offsets, field positions and timing counts live here, plus the mode, scaling and half-cycle reset values
package epl_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned SAMPLE_DIV      = 4;        // master clocks per energy sample
  localparam int unsigned CAL_PULSE_NS    = 10000;    // calibration pulse high time
  localparam int unsigned CAL_PULSE_CYC   = (CAL_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CAL_CNT_W       = 12;

  // widths
  localparam int unsigned PWR_W           = 24;       // active power sample
  localparam int unsigned ACC_W           = 48;       // internal energy accumulator
  localparam int unsigned WORD_W          = 24;       // readable energy word
  localparam int unsigned SCALE_W         = 12;       // frequency scaling registers
  localparam int unsigned LCYC_W          = 16;       // half-cycle count

  // no-load threshold: 0.001 % of multiplier full scale
  localparam logic [PWR_W-1:0] PWR_FULL_SCALE = 24'h7FFFFF;
  localparam logic [PWR_W-1:0] NOLOAD_THRESH  = PWR_W'(PWR_FULL_SCALE / 100000);

  // register byte offsets
  localparam logic [7:0] OFS_LINE_ENERGY  = 8'h04;
  localparam logic [7:0] OFS_ENERGY_WORD  = 8'h08;
  localparam logic [7:0] OFS_MODE         = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h14;
  localparam logic [7:0] OFS_FREQ_NUM     = 8'h18;
  localparam logic [7:0] OFS_HALF_CYCLES  = 8'h1C;
  localparam logic [7:0] OFS_FREQ_DEN     = 8'h20;

  // field positions
  localparam int unsigned MODE_LINE_CYCLE_BIT = 7;
  localparam int unsigned MODE_POS_ONLY_BIT   = 15;
  localparam int unsigned IRQ_CYCLE_END_BIT   = 2;
  localparam int unsigned IRQ_WENT_POS_BIT    = 4;
  localparam int unsigned IRQ_WENT_NEG_BIT    = 5;

  // reset values
  localparam logic [15:0]        MODE_RESET   = 16'h0000;
  localparam logic [SCALE_W-1:0] SCALE_RESET  = 12'h000;
  localparam logic [LCYC_W-1:0]  LCYC_RESET   = 16'hFFFF;

  // event group shared by status and enable registers
  typedef struct packed {
    logic went_neg;
    logic went_pos;
    logic cycle_end;
  } epl_evt_t;

  // software-visible mode bits
  typedef struct packed {
    logic pos_only;
    logic line_cycle_mode_bit;
  } epl_mode_t;

  typedef enum logic [0:0] {
    LC_IDLE,
    LC_RUN
  } epl_lc_state_t;

endpackage

// [hw/epl_energy_pulse.sv]
// Purpose: active energy accumulation, calibration pulse output and line-cycle accumulation
// Assumes: power samples come from logic on pclk; zero-crossing input is asynchronous
`timescale 1ns/1ps

module epl_energy_pulse
  import epl_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [PWR_W-1:0]  power_lowpass,
  input  wire logic              zero_cross_in,
  output logic                   cal_pulse_out,
  output logic                   irq_n_o,
  output logic                   irq_n_oe
);

  // absolute value of a signed power sample
  function automatic logic [PWR_W-1:0] abs_pwr(input logic [PWR_W-1:0] v);
    abs_pwr = v[PWR_W-1] ? PWR_W'(~v + 1'b1) : v;
  endfunction

  // zero written to a scaling register becomes one
  function automatic logic [SCALE_W-1:0] fix_scale(input logic [31:0] v);
    fix_scale = (v[SCALE_W-1:0] == '0) ? SCALE_W'(1) : v[SCALE_W-1:0];
  endfunction

  // registers
  epl_mode_t           mode;
  epl_evt_t            irq_enable;
  epl_evt_t            irq_status;
  logic [SCALE_W-1:0]  pulse_freq_numerator;
  logic [SCALE_W-1:0]  pulse_freq_denominator;
  logic [LCYC_W-1:0]   half_cycle_count;
  logic [WORD_W-1:0]   line_active_energy_result;

  // datapath state
  logic [1:0]          sample_phase;
  logic                sample_take;
  logic [ACC_W-1:0]    energy_acc;
  logic [ACC_W-1:0]    line_acc;
  logic [ACC_W-1:0]    next_energy_acc;
  logic                add_ok;
  logic                sample_neg;
  logic                last_neg;
  logic                dir_known;
  logic                dfc_pulse;
  logic [SCALE_W:0]    frac_acc;
  logic [CAL_CNT_W-1:0] cal_cnt;
  logic                zx_meta;
  logic                zx_sync;
  logic                zx_prev;
  logic                zx_event;
  epl_lc_state_t       lc_state;
  logic [LCYC_W-1:0]   lc_remaining;
  logic                lc_end;
  logic                went_pos_evt;
  logic                went_neg_evt;

  // bus decode
  logic                bus_setup;
  logic                bus_write;
  logic                addr_ok;
  logic [31:0]         next_prdata;
  logic                st_clr;

  assign bus_setup = psel & ~penable;
  assign bus_write = psel & penable & pready & pwrite;
  assign st_clr    = bus_write & (paddr == OFS_IRQ_STATUS);

  // read mux and address check
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    addr_ok     = 1'b1;
    unique case (paddr)
      OFS_LINE_ENERGY: next_prdata[WORD_W-1:0] = line_active_energy_result;
      OFS_ENERGY_WORD: next_prdata[WORD_W-1:0] = energy_acc[ACC_W-1 -: WORD_W];
      OFS_MODE:
      begin
        next_prdata[MODE_LINE_CYCLE_BIT] = mode.line_cycle_mode_bit;
        next_prdata[MODE_POS_ONLY_BIT]   = mode.pos_only;
      end
      OFS_IRQ_ENABLE:
      begin
        next_prdata[IRQ_CYCLE_END_BIT] = irq_enable.cycle_end;
        next_prdata[IRQ_WENT_POS_BIT]  = irq_enable.went_pos;
        next_prdata[IRQ_WENT_NEG_BIT]  = irq_enable.went_neg;
      end
      OFS_IRQ_STATUS:
      begin
        next_prdata[IRQ_CYCLE_END_BIT] = irq_status.cycle_end;
        next_prdata[IRQ_WENT_POS_BIT]  = irq_status.went_pos;
        next_prdata[IRQ_WENT_NEG_BIT]  = irq_status.went_neg;
      end
      OFS_FREQ_NUM:    next_prdata[SCALE_W-1:0] = pulse_freq_numerator;
      OFS_HALF_CYCLES: next_prdata[LCYC_W-1:0]  = half_cycle_count;
      OFS_FREQ_DEN:    next_prdata[SCALE_W-1:0] = pulse_freq_denominator;
      default:         addr_ok = 1'b0;
    endcase
  end

  // apb answer: data, ready and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= bus_setup;
      pslverr <= bus_setup & ~addr_ok;
      prdata  <= bus_setup ? next_prdata : 32'h0000_0000;
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode.line_cycle_mode_bit <= MODE_RESET[MODE_LINE_CYCLE_BIT];
      mode.pos_only            <= MODE_RESET[MODE_POS_ONLY_BIT];
      irq_enable               <= '0;
      pulse_freq_numerator     <= SCALE_RESET;
      pulse_freq_denominator   <= SCALE_RESET;
      half_cycle_count         <= LCYC_RESET;
    end
    else if (bus_write)
    begin
      unique case (paddr)
        OFS_MODE:
        begin
          mode.line_cycle_mode_bit <= pwdata[MODE_LINE_CYCLE_BIT];
          mode.pos_only            <= pwdata[MODE_POS_ONLY_BIT];
        end
        OFS_IRQ_ENABLE:
        begin
          irq_enable.cycle_end <= pwdata[IRQ_CYCLE_END_BIT];
          irq_enable.went_pos  <= pwdata[IRQ_WENT_POS_BIT];
          irq_enable.went_neg  <= pwdata[IRQ_WENT_NEG_BIT];
        end
        OFS_FREQ_NUM:    pulse_freq_numerator   <= fix_scale(pwdata);
        OFS_FREQ_DEN:    pulse_freq_denominator <= fix_scale(pwdata);
        OFS_HALF_CYCLES: half_cycle_count       <= pwdata[LCYC_W-1:0];
        default:         ;
      endcase
    end
  end

  // sample strobe: one accumulation every four clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_phase <= 2'h0;
      sample_take  <= 1'b0;
    end
    else
    begin
      sample_phase <= sample_phase + 2'h1;
      sample_take  <= (sample_phase == 2'(SAMPLE_DIV - 1));
    end
  end

  // gating of the sample: no-load threshold and positive-only mode
  assign sample_neg = power_lowpass[PWR_W-1];
  assign add_ok     = (abs_pwr(power_lowpass) >= NOLOAD_THRESH)
                    & ~(mode.pos_only & sample_neg);
  assign next_energy_acc = energy_acc + {{(ACC_W-PWR_W){sample_neg}}, power_lowpass};

  // main signed accumulator and converter pulse on word LSB movement
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      energy_acc <= '0;
      dfc_pulse  <= 1'b0;
    end
    else
    begin
      dfc_pulse <= 1'b0;
      if (sample_take && add_ok)
      begin
        energy_acc <= next_energy_acc;
        // each add moves the word by at most one LSB, so a bit change marks it
        dfc_pulse  <= next_energy_acc[ACC_W-WORD_W] != energy_acc[ACC_W-WORD_W];
      end
    end
  end

  // power direction tracking on samples above the no-load floor
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_neg     <= 1'b0;
      dir_known    <= 1'b0;
      went_pos_evt <= 1'b0;
      went_neg_evt <= 1'b0;
    end
    else
    begin
      went_pos_evt <= 1'b0;
      went_neg_evt <= 1'b0;
      if (sample_take && abs_pwr(power_lowpass) >= NOLOAD_THRESH)
      begin
        dir_known    <= 1'b1;
        last_neg     <= sample_neg;
        went_pos_evt <= dir_known & last_neg & ~sample_neg;
        went_neg_evt <= dir_known & ~last_neg & sample_neg;
      end
    end
  end

  // divider: add numerator+1 per converter pulse, emit when denominator+1 reached
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frac_acc <= '0;
      cal_cnt  <= '0;
    end
    else
    begin
      if (cal_cnt != '0)
        cal_cnt <= cal_cnt - CAL_CNT_W'(1);
      if (dfc_pulse)
      begin
        if (pulse_freq_numerator >= pulse_freq_denominator)
        begin
          frac_acc <= '0;
          cal_cnt  <= CAL_CNT_W'(CAL_PULSE_CYC);
        end
        else if (frac_acc + {1'b0, pulse_freq_numerator} + 1'b1 >= {1'b0, pulse_freq_denominator} + 1'b1)
        begin
          frac_acc <= frac_acc + {1'b0, pulse_freq_numerator} - {1'b0, pulse_freq_denominator};
          cal_cnt  <= CAL_CNT_W'(CAL_PULSE_CYC);
        end
        else
          frac_acc <= frac_acc + {1'b0, pulse_freq_numerator} + 1'b1;
      end
    end
  end

  // calibration pulse drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_pulse_out <= 1'b0;
    else
      cal_pulse_out <= (cal_cnt != '0);
  end

  // zero-crossing synchroniser and edge detect, both edges count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zx_meta  <= 1'b0;
      zx_sync  <= 1'b0;
      zx_prev  <= 1'b0;
    end
    else
    begin
      zx_meta <= zero_cross_in;
      zx_sync <= zx_meta;
      zx_prev <= zx_sync;
    end
  end

  assign zx_event = zx_sync ^ zx_prev;

  // line-cycle sequencer: count half cycles, latch result, restart
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lc_state     <= LC_IDLE;
      lc_remaining <= LCYC_RESET;
      lc_end       <= 1'b0;
    end
    else
    begin
      lc_end <= 1'b0;
      unique case (lc_state)
        LC_IDLE:
        begin
          if (mode.line_cycle_mode_bit)
          begin
            lc_state     <= LC_RUN;
            lc_remaining <= half_cycle_count;
          end
        end
        LC_RUN:
        begin
          if (!mode.line_cycle_mode_bit)
            lc_state <= LC_IDLE;
          else if (zx_event)
          begin
            if (lc_remaining <= LCYC_W'(1))
            begin
              lc_end       <= 1'b1;
              lc_remaining <= half_cycle_count;
            end
            else
              lc_remaining <= lc_remaining - LCYC_W'(1);
          end
        end
      endcase
    end
  end

  // line energy accumulator and result latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_acc                  <= '0;
      line_active_energy_result <= '0;
    end
    else
    begin
      if (lc_state == LC_IDLE || lc_end)
        line_acc <= '0;
      else if (sample_take && add_ok)
        line_acc <= line_acc + {{(ACC_W-PWR_W){sample_neg}}, power_lowpass};
      if (lc_end)
        line_active_energy_result <= line_acc[ACC_W-1 -: WORD_W];
    end
  end

  // sticky status, write one to clear, a new event beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= '0;
    end
    else
    begin
      irq_status.cycle_end <= lc_end | (irq_status.cycle_end & ~(st_clr & pwdata[IRQ_CYCLE_END_BIT]));
      irq_status.went_pos  <= went_pos_evt | (irq_status.went_pos & ~(st_clr & pwdata[IRQ_WENT_POS_BIT]));
      irq_status.went_neg  <= went_neg_evt | (irq_status.went_neg & ~(st_clr & pwdata[IRQ_WENT_NEG_BIT]));
    end
  end

  // open-drain interrupt request: pull low while an enabled flag stands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_n_oe <= 1'b0;
      irq_n_o  <= 1'b0;
    end
    else
    begin
      irq_n_oe <= |(irq_status & irq_enable);
      irq_n_o  <= 1'b0;
    end
  end

endmodule

// [verification/epl_energy_pulse_asserts.sv]
// Purpose: port-level checks for epl_energy_pulse
// Assumes: one pclk domain, presetn async active low
// Notes: bound to every instance of the block
`timescale 1ns/1ps

module epl_energy_pulse_asserts
  import epl_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [PWR_W-1:0] power_lowpass,
  input wire logic             zero_cross_in,
  input wire logic             cal_pulse_out,
  input wire logic             irq_n_o,
  input wire logic             irq_n_oe
);
  logic [11:0] hi_cnt;

  // length of the current calibration pulse, saturating
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_cnt <= 12'h000;
    else if (!cal_pulse_out)
      hi_cnt <= 12'h000;
    else if (hi_cnt != 12'hFFF)
      hi_cnt <= hi_cnt + 12'h001;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence

  property p_ready_after_setup;
    s_setup |=> pready && psel && penable;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_mapped;
    pready && paddr == OFS_MODE |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("error on mapped register");
  property p_scale_width;
    pready && !pwrite && (paddr == OFS_FREQ_NUM || paddr == OFS_FREQ_DEN) |-> prdata[31:12] == 20'h00000;
  endproperty
  a_scale_width: assert property (p_scale_width) else $error("scaler wider than twelve bits");
  property p_count_width;
    s_rd(OFS_HALF_CYCLES) |-> prdata[31:16] == 16'h0000 && !pslverr;
  endproperty
  a_count_width: assert property (p_count_width) else $error("half-cycle count too wide");
  property p_word_width;
    pready && !pwrite && (paddr == OFS_LINE_ENERGY || paddr == OFS_ENERGY_WORD) |-> prdata[31:24] == 8'h00;
  endproperty
  a_word_width: assert property (p_word_width) else $error("energy word too wide");
  property p_irq_low;
    irq_n_oe |-> irq_n_o == 1'b0;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt pin not pulled low");
  property p_pulse_width;
    $fell(cal_pulse_out) |-> hi_cnt >= CAL_PULSE_CYC;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("calibration pulse too short");
endmodule

bind epl_energy_pulse epl_energy_pulse_asserts epl_energy_pulse_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .power_lowpass(power_lowpass), .zero_cross_in(zero_cross_in), .cal_pulse_out(cal_pulse_out),
  .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
);

// [verification/epl_cal_counter.sv]
// Purpose: calibration equipment model that counts output pulses
// Assumes: pulse is a registered level on pclk
// Notes: the bench clears the count before each run
`timescale 1ns/1ps

module epl_cal_counter
(
  input  wire logic pclk,
  input  wire logic pulse,
  input  wire logic clear,
  output int        count
);
  logic last;

  // count rising edges only, merged pulses count once
  always_ff @(posedge pclk)
  begin
    last <= pulse;
    if (clear)
      count <= 0;
    else if (pulse && !last)
      count <= count + 1;
  end
endmodule

// [verification/epl_energy_pulse_test.sv]
// Purpose: self-checking bench for epl_energy_pulse
// Assumes: APB master on pclk, partner counts calibration pulses
// Notes: random power values come from a 16-bit lfsr
`timescale 1ns/1ps

module epl_energy_pulse_test
  import epl_pkg::*;
;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [PWR_W-1:0] power_lowpass;
  wire              zero_cross_in;
  logic             cal_pulse_out;
  logic             irq_n_o;
  logic             irq_n_oe;
  logic             zx_on;
  logic [5:0]       zx_div = 6'h00;
  logic             clr;
  logic [31:0]      rd;
  logic             err;
  logic [31:0]      w0;
  logic [15:0]      lfsr;
  logic [23:0]      v;
  int               n_fail;
  int               checked;
  int               pulses;

  epl_energy_pulse epl_energy_pulse_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_lowpass(power_lowpass), .zero_cross_in(zero_cross_in), .cal_pulse_out(cal_pulse_out),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe)
  );
  epl_cal_counter epl_cal_counter_inst (.pclk(pclk), .pulse(cal_pulse_out), .clear(clr), .count(pulses));

  // 250 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // zero-crossing source, one edge every 32 clocks while enabled
  always @(posedge pclk)
    if (zx_on)
      zx_div <= zx_div + 6'h01;
  assign zero_cross_in = zx_div[5];

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // energy word steps after n samples of power p
  function automatic logic [31:0] steps(input longint p, input longint n);
    return 32'((p * n) >>> 24);
  endfunction

  // output pulses for k converter steps, zero read as one, ratio capped at one
  function automatic logic [31:0] ratio(input int k, input int n, input int d, input bit hi);
    int a;
    int b;
    a = (n == 0) ? 1 : n;
    b = (d == 0) ? 1 : d;
    a = (a > b) ? b : a;
    return 32'((k * (a + 1) + (hi ? b : 0)) / (b + 1));
  endfunction

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_rng(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("mismatch at %0t exp %h..%h got %h", $time, lo, hi, g);
    end
  endtask

  // one APB transfer, result left in rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, rd);
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic pw(input logic [23:0] p);
    @(posedge pclk);
    power_lowpass <= p;
  endtask

  // read status until the masked bits are set, bounded
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFS_IRQ_STATUS, 32'h0);
      n++;
    end
    while ((rd & m) !== m && n < 100);
    chk(m, rd & m);
    if ((rd & m) !== m)
      finish_test();
  endtask

  // count output pulses against converter steps seen in the energy word
  task automatic run_cal(input logic [23:0] p, input int n, input int d);
    clk(3000);
    apb(1'b0, OFS_ENERGY_WORD, 32'h0);
    w0 = rd;
    clr <= 1'b1;
    pw(p);
    clr <= 1'b0;
    clk(16384);
    pw(24'h0);
    clk(16);
    apb(1'b0, OFS_ENERGY_WORD, 32'h0);
    chk_rng(ratio(int'((rd - w0) & 32'hFF_FFFF), n, d, 1'b0), ratio(int'((rd - w0) & 32'hFF_FFFF), n, d, 1'b1),
            pulses);
  endtask

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    power_lowpass = 24'h0;
    zx_on = 1'b0;
    clr = 1'b0;
    n_fail = 0;
    checked = 0;
    lfsr = 16'h8E45;
    presetn = 1'b0;
    clk(4);
    presetn <= 1'b1;
    // reset values, zero substitution, read-only and unmapped places
    rdc(OFS_MODE, {16'h0, MODE_RESET});
    rdc(OFS_HALF_CYCLES, {16'h0, LCYC_RESET});
    rdc(OFS_FREQ_NUM, {20'h0, SCALE_RESET});
    wr(OFS_FREQ_NUM, 32'hFFFF_F000);
    rdc(OFS_FREQ_NUM, 32'h1);
    wr(OFS_FREQ_DEN, 32'h0);
    rdc(OFS_FREQ_DEN, 32'h1);
    wr(OFS_HALF_CYCLES, 32'hABCD_FFFF);
    rdc(OFS_HALF_CYCLES, 32'hFFFF);
    apb(1'b0, OFS_LINE_ENERGY, 32'h0);
    w0 = rd;
    wr(OFS_LINE_ENERGY, 32'h00FF_FFFF);
    rdc(OFS_LINE_ENERGY, w0);
    apb(1'b0, 8'hFC, 32'h0);
    chk(32'h1, {31'h0, err});
    $display("test registers done");
    // creep below the no-load level, then negatives in positive-only mode
    apb(1'b0, OFS_ENERGY_WORD, 32'h0);
    w0 = rd;
    repeat (64)
    begin
      lfsr = nxt(lfsr);
      v = 24'(lfsr) % NOLOAD_THRESH;
      pw(lfsr[0] ? -v : v);
    end
    pw(24'h0);
    rdc(OFS_ENERGY_WORD, w0);
    wr(OFS_MODE, 32'h0000_8000);
    repeat (64)
    begin
      lfsr = nxt(lfsr);
      pw({1'b1, lfsr, 7'h00});
    end
    pw(24'h0);
    rdc(OFS_ENERGY_WORD, w0);
    wr(OFS_MODE, 32'h0);
    // signed accumulation, one sample per four clocks
    pw(PWR_FULL_SCALE);
    clk(399);
    pw(24'h0);
    clk(8);
    apb(1'b0, OFS_ENERGY_WORD, 32'h0);
    chk_rng(steps(PWR_FULL_SCALE, 99), steps(PWR_FULL_SCALE, 101) + 1, (rd - w0) & 32'hFF_FFFF);
    w0 = rd;
    pw(-PWR_FULL_SCALE);
    clk(399);
    pw(24'h0);
    clk(8);
    apb(1'b0, OFS_ENERGY_WORD, 32'h0);
    chk_rng(steps(PWR_FULL_SCALE, 99), steps(PWR_FULL_SCALE, 101) + 1, (w0 - rd) & 32'hFF_FFFF);
    $display("test accumulation done");
    // clamped ratio, then a true division
    wr(OFS_FREQ_NUM, 32'h5);
    wr(OFS_FREQ_DEN, 32'h2);
    run_cal(24'h004000, 5, 2);
    wr(OFS_FREQ_NUM, 32'h0);
    wr(OFS_FREQ_DEN, 32'h3);
    run_cal(24'h008000, 0, 3);
    $display("test calibration pulses done");
    // direction changes, one enabled and one masked
    wr(OFS_IRQ_ENABLE, 32'h20);
    pw(24'h100000);
    clk(12);
    wr(OFS_IRQ_STATUS, 32'hFF);
    pw(24'hF00000);
    clk(12);
    rdc(OFS_IRQ_STATUS, 32'h20);
    chk(32'h1, {31'h0, irq_n_oe});
    wr(OFS_IRQ_STATUS, 32'h20);
    pw(24'h100000);
    clk(12);
    rdc(OFS_IRQ_STATUS, 32'h10);
    chk(32'h0, {31'h0, irq_n_oe});
    wr(OFS_IRQ_ENABLE, 32'h10);
    clk(2);
    chk(32'h1, {31'h0, irq_n_oe});
    wr(OFS_IRQ_STATUS, 32'hFF);
    $display("test direction done");
    // line-cycle periods of two half cycles, restarting by themselves
    pw(PWR_FULL_SCALE);
    wr(OFS_HALF_CYCLES, 32'h2);
    wr(OFS_IRQ_ENABLE, 32'h4);
    zx_on <= 1'b1;
    wr(OFS_MODE, 32'h80);
    poll(32'h4);
    clk(3);
    chk(32'h1, {31'h0, irq_n_oe});
    wr(OFS_IRQ_STATUS, 32'h4);
    poll(32'h4);
    apb(1'b0, OFS_LINE_ENERGY, 32'h0);
    chk_rng(steps(PWR_FULL_SCALE, 15), steps(PWR_FULL_SCALE, 17) + 1, rd);
    wr(OFS_MODE, 32'h0);
    zx_on <= 1'b0;
    $display("test line cycle done");
    finish_test();
  end
endmodule
